// ---- supervisor_pkg.sv ----
// Constants, register map and state types of the fault and warning supervisor
package supervisor_pkg;

  // Register offsets, 16-bit parameter space
  localparam logic [15:0] REG_FAULT_CLEAR      = 16'h0003;
  localparam logic [15:0] REG_WARN_STATUS      = 16'h4015;
  localparam logic [15:0] REG_FAULT_LOW        = 16'h4016;
  localparam logic [15:0] REG_FAULT_HIGH       = 16'h4017;
  localparam logic [15:0] REG_WARN_STATUS_EXT  = 16'h4020;
  localparam logic [15:0] REG_RECONNECT_EN     = 16'h803E;
  localparam logic [15:0] REG_RECONNECT_DELAY  = 16'h803F;
  localparam logic [15:0] REG_LINK_OV_WARN     = 16'h8045;
  localparam logic [15:0] REG_LINK_UV_FAULT    = 16'h8046;
  localparam logic [15:0] REG_LINK_UV_WARN     = 16'h8047;
  localparam logic [15:0] REG_CUR_WARN         = 16'h8049;
  localparam logic [15:0] REG_GRID_OV_WARN     = 16'h804B;
  localparam logic [15:0] REG_LINK_OV_DELTA    = 16'h8052;
  localparam logic [15:0] REG_LINK_UV_DELTA    = 16'h8053;
  localparam logic [15:0] REG_CUR_DELTA        = 16'h8054;
  localparam logic [15:0] REG_GRID_OV_DELTA    = 16'h8055;
  localparam logic [15:0] REG_PIN_CLEAR_EN     = 16'h8063;
  localparam logic [15:0] REG_EXT_THERM_EN     = 16'h80BC;
  localparam logic [15:0] REG_EXT_WARN         = 16'h80C4;
  localparam logic [15:0] REG_EXT_DELTA        = 16'h80C5;

  // Reset values of the parameters
  localparam logic [15:0] OVER_LEVEL_RESET  = 16'hFFFF;
  localparam logic [15:0] UNDER_LEVEL_RESET = 16'h0000;
  localparam logic [15:0] DELTA_RESET       = 16'h0000;
  localparam logic [15:0] ENABLE_RESET      = 16'h0000;
  localparam logic [15:0] DELAY_RESET       = 16'h0000;

  // Warning word bit positions
  localparam int W_LINK_HIGH  = 0;
  localparam int W_LINK_LOW   = 1;
  localparam int W_LINK_UNDER = 2;
  localparam int W_CUR0       = 3;
  localparam int W_FREQ       = 6;
  localparam int W_GRID_TOL0  = 7;
  localparam int W_GRID_HIGH0 = 10;
  localparam int W_MOD_TEMP   = 13;
  localparam int W_BOARD_TEMP = 14;
  localparam int W_EXT_TEMP   = 15;
  localparam int WX_PLL       = 0;
  localparam int WX_BIAS15    = 1;
  localparam int WX_BIAS5     = 2;

  // Fault source bit positions; bits 6 to 9 are the grid tolerance faults
  localparam int F_DESAT0     = 0;
  localparam int F_GATE0      = 3;
  localparam logic [31:0] GRID_FAULT_MASK = 32'h0000_03C0;

  // Fixed temperature limits, whole degrees C
  localparam logic [15:0] MOD_TEMP_SET_C     = 16'h006E;
  localparam logic [15:0] MOD_TEMP_CLEAR_C   = 16'h0069;
  localparam logic [15:0] BOARD_TEMP_SET_C   = 16'h0055;
  localparam logic [15:0] BOARD_TEMP_CLEAR_C = 16'h0050;

  // Reconnect delay counts in units of this period
  localparam int CLK_KHZ            = 25000;
  localparam int RECONNECT_UNIT_US  = 1000;
  localparam int RECONNECT_UNIT_CYC = CLK_KHZ * RECONNECT_UNIT_US / 1000;

  typedef enum logic [2:0] {
    ST_CALIBRATE = 3'b000,
    ST_WAIT_DC   = 3'b001,
    ST_READY     = 3'b010,
    ST_ON        = 3'b011,
    ST_FAULT     = 3'b100
  } op_state_t;

  typedef struct packed {
    logic [15:0]      link_v;
    logic [2:0][15:0] phase_cur;
    logic [2:0][15:0] grid_v;
    logic [2:0][15:0] module_temp;
    logic [15:0]      board_temp;
    logic [15:0]      ext_temp;
    logic             freq_in_tol;
    logic [2:0]       grid_v_in_tol;
    logic             pll_locked;
    logic             bias15_ok;
    logic             bias5_ok;
  } meas_t;

  typedef struct packed {
    logic [15:0] reconnect_en;
    logic [15:0] reconnect_delay;
    logic [15:0] link_ov_warn;
    logic [15:0] link_uv_fault;
    logic [15:0] link_uv_warn;
    logic [15:0] cur_warn;
    logic [15:0] grid_ov_warn;
    logic [15:0] link_ov_delta;
    logic [15:0] link_uv_delta;
    logic [15:0] cur_delta;
    logic [15:0] grid_ov_delta;
    logic [15:0] pin_clear_en;
    logic [15:0] ext_therm_en;
    logic [15:0] ext_warn;
    logic [15:0] ext_delta;
  } cfg_t;

  typedef struct packed {
    op_state_t   state;
    logic        power_on;
    logic        contact;
    logic        fault_out;
    logic [31:0] latched;
    logic [15:0] warn;
    logic [2:0]  warn_ext;
    logic        pin_prev;
    logic [15:0] tick_cnt;
    logic [15:0] rc_cnt;
    logic [15:0] rdata;
    cfg_t        cfg;
  } sup_state_t;

endpackage

// ---- fault_warning_supervisor.sv ----
// Fault latching, fault state sequencing and warning flags of the inverter
// Summary of operation
// - Any fault: stage off, contactors open, fault
// - Leave fault only on clear write/pin edge or grid-only auto-clear
// - Turn-on requests ignored in fault except on auto-clear
// - Grid-only faults auto-clear after in-tolerance delay
// - Clean reset goes to calibrate or wait-DC
// - Reset clears latches, still-active sources relatch
// - Warnings only flag status, never block operation
// - Link high warning with recover hysteresis
// - Link low warning with recover hysteresis
// - Under-voltage warning below fault level, always
// - Per-phase high current warning with hysteresis
// - Frequency warning follows tolerance, no latch
// - Per-pair grid tolerance warning, no latch
// - Per-pair high grid voltage warning, hysteresis
// - Module temperature warning 110 set, 105 clear
// - Board temperature warning 85 set, 80 clear
// - External temperature warning only when enabled
// - Sync warning follows PLL lock loss
// - Two bias supply warnings follow range, unlatched
// - Each fault latched in one bit of two status words
// - Fault indicator pin high while any latched
// - Desaturation and gate faults latched per phase
`timescale 1ns/100ps
`default_nettype none
module fault_warning_supervisor #(
  parameter int TICK_CYCLES = supervisor_pkg::RECONNECT_UNIT_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [15:0]           addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output var  logic [15:0]           rdata,
  input  wire supervisor_pkg::meas_t meas,
  input  wire logic [31:0]           fault_sources,
  input  wire logic                  on_request,
  input  wire logic                  calibration_done,
  input  wire logic                  sequence_ready,
  input  wire logic                  fault_clear_pin,
  output var  logic                  power_stage_on,
  output var  logic                  contactor_close,
  output var  logic                  fault_indicator_pin,
  output var  supervisor_pkg::op_state_t op_state
);

  supervisor_pkg::sup_state_t st;
  supervisor_pkg::sup_state_t next_st;
  logic                       any_src;
  logic                       clear_evt;
  logic                       grid_only;
  logic                       auto_evt;
  logic                       tick;

  // Set above th, clear only below th - d; a delta above th never clears
  function automatic logic hyst_over(input logic flag,
                                     input logic [15:0] v,
                                     input logic [15:0] th,
                                     input logic [15:0] d);
    logic r;
    r = flag;
    if (v > th)
      r = 1'b1;
    else if (th >= d && v < th - d)
      r = 1'b0;
    return r;
  endfunction

  // Set below th, clear only above th + d, sum kept at 17 bits
  function automatic logic hyst_under(input logic flag,
                                      input logic [15:0] v,
                                      input logic [15:0] th,
                                      input logic [15:0] d);
    logic r;
    r = flag;
    if (v < th)
      r = 1'b1;
    else if ({1'b0, v} > {1'b0, th} + {1'b0, d})
      r = 1'b0;
    return r;
  endfunction

  always_comb
  begin
    any_src   = |fault_sources;
    tick      = (st.tick_cnt == 16'(TICK_CYCLES - 1));
    clear_evt = (wr_en && addr == supervisor_pkg::REG_FAULT_CLEAR) ||
                (st.cfg.pin_clear_en[0] && fault_clear_pin &&
                 !st.pin_prev);
    grid_only = (st.latched != 32'h0000_0000) &&
                ((st.latched & ~supervisor_pkg::GRID_FAULT_MASK) ==
                 32'h0000_0000);
    auto_evt  = st.cfg.reconnect_en[0] && st.state == supervisor_pkg::ST_FAULT
                && grid_only && !any_src && meas.freq_in_tol &&
                (&meas.grid_v_in_tol) &&
                (st.rc_cnt > st.cfg.reconnect_delay);
  end

  always_comb
  begin
    next_st          = st;
    next_st.pin_prev = fault_clear_pin;
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    next_st.rdata    = 16'h0000;

    // Parameter writes
    if (wr_en)
    begin
      if (addr == supervisor_pkg::REG_RECONNECT_EN)
        next_st.cfg.reconnect_en = wdata;
      else if (addr == supervisor_pkg::REG_RECONNECT_DELAY)
        next_st.cfg.reconnect_delay = wdata;
      else if (addr == supervisor_pkg::REG_LINK_OV_WARN)
        next_st.cfg.link_ov_warn = wdata;
      else if (addr == supervisor_pkg::REG_LINK_UV_FAULT)
        next_st.cfg.link_uv_fault = wdata;
      else if (addr == supervisor_pkg::REG_LINK_UV_WARN)
        next_st.cfg.link_uv_warn = wdata;
      else if (addr == supervisor_pkg::REG_CUR_WARN)
        next_st.cfg.cur_warn = wdata;
      else if (addr == supervisor_pkg::REG_GRID_OV_WARN)
        next_st.cfg.grid_ov_warn = wdata;
      else if (addr == supervisor_pkg::REG_LINK_OV_DELTA)
        next_st.cfg.link_ov_delta = wdata;
      else if (addr == supervisor_pkg::REG_LINK_UV_DELTA)
        next_st.cfg.link_uv_delta = wdata;
      else if (addr == supervisor_pkg::REG_CUR_DELTA)
        next_st.cfg.cur_delta = wdata;
      else if (addr == supervisor_pkg::REG_GRID_OV_DELTA)
        next_st.cfg.grid_ov_delta = wdata;
      else if (addr == supervisor_pkg::REG_PIN_CLEAR_EN)
        next_st.cfg.pin_clear_en = wdata;
      else if (addr == supervisor_pkg::REG_EXT_THERM_EN)
        next_st.cfg.ext_therm_en = wdata;
      else if (addr == supervisor_pkg::REG_EXT_WARN)
        next_st.cfg.ext_warn = wdata;
      else if (addr == supervisor_pkg::REG_EXT_DELTA)
        next_st.cfg.ext_delta = wdata;
    end

    // Reads only copy state out; no flag is touched here
    if (rd_en)
    begin
      if (addr == supervisor_pkg::REG_WARN_STATUS)
        next_st.rdata = st.warn;
      else if (addr == supervisor_pkg::REG_WARN_STATUS_EXT)
        next_st.rdata = {13'h0000, st.warn_ext};
      else if (addr == supervisor_pkg::REG_FAULT_LOW)
        next_st.rdata = st.latched[15:0];
      else if (addr == supervisor_pkg::REG_FAULT_HIGH)
        next_st.rdata = st.latched[31:16];
      else if (addr == supervisor_pkg::REG_RECONNECT_EN)
        next_st.rdata = st.cfg.reconnect_en;
      else if (addr == supervisor_pkg::REG_RECONNECT_DELAY)
        next_st.rdata = st.cfg.reconnect_delay;
      else if (addr == supervisor_pkg::REG_LINK_OV_WARN)
        next_st.rdata = st.cfg.link_ov_warn;
      else if (addr == supervisor_pkg::REG_LINK_UV_FAULT)
        next_st.rdata = st.cfg.link_uv_fault;
      else if (addr == supervisor_pkg::REG_LINK_UV_WARN)
        next_st.rdata = st.cfg.link_uv_warn;
      else if (addr == supervisor_pkg::REG_CUR_WARN)
        next_st.rdata = st.cfg.cur_warn;
      else if (addr == supervisor_pkg::REG_GRID_OV_WARN)
        next_st.rdata = st.cfg.grid_ov_warn;
      else if (addr == supervisor_pkg::REG_LINK_OV_DELTA)
        next_st.rdata = st.cfg.link_ov_delta;
      else if (addr == supervisor_pkg::REG_LINK_UV_DELTA)
        next_st.rdata = st.cfg.link_uv_delta;
      else if (addr == supervisor_pkg::REG_CUR_DELTA)
        next_st.rdata = st.cfg.cur_delta;
      else if (addr == supervisor_pkg::REG_GRID_OV_DELTA)
        next_st.rdata = st.cfg.grid_ov_delta;
      else if (addr == supervisor_pkg::REG_PIN_CLEAR_EN)
        next_st.rdata = st.cfg.pin_clear_en;
      else if (addr == supervisor_pkg::REG_EXT_THERM_EN)
        next_st.rdata = st.cfg.ext_therm_en;
      else if (addr == supervisor_pkg::REG_EXT_WARN)
        next_st.rdata = st.cfg.ext_warn;
      else if (addr == supervisor_pkg::REG_EXT_DELTA)
        next_st.rdata = st.cfg.ext_delta;
    end

    // Warnings feed only the status words, never the sequencer
    next_st.warn[supervisor_pkg::W_LINK_HIGH] =
      hyst_over(st.warn[supervisor_pkg::W_LINK_HIGH], meas.link_v,
                st.cfg.link_ov_warn, st.cfg.link_ov_delta);
    next_st.warn[supervisor_pkg::W_LINK_LOW] =
      hyst_under(st.warn[supervisor_pkg::W_LINK_LOW], meas.link_v,
                 st.cfg.link_uv_warn, st.cfg.link_uv_delta);
    next_st.warn[supervisor_pkg::W_LINK_UNDER] =
      meas.link_v < st.cfg.link_uv_fault;
    next_st.warn[supervisor_pkg::W_FREQ] = !meas.freq_in_tol;
    for (int i = 0; i < 3; i++)
    begin
      next_st.warn[supervisor_pkg::W_CUR0 + i] =
        hyst_over(st.warn[supervisor_pkg::W_CUR0 + i], meas.phase_cur[i],
                  st.cfg.cur_warn, st.cfg.cur_delta);
      next_st.warn[supervisor_pkg::W_GRID_TOL0 + i] =
        !meas.grid_v_in_tol[i];
      next_st.warn[supervisor_pkg::W_GRID_HIGH0 + i] =
        hyst_over(st.warn[supervisor_pkg::W_GRID_HIGH0 + i], meas.grid_v[i],
                  st.cfg.grid_ov_warn, st.cfg.grid_ov_delta);
    end
    // One flag for all modules: set by any hot one, cleared when all cool
    if (meas.module_temp[0] > supervisor_pkg::MOD_TEMP_SET_C ||
        meas.module_temp[1] > supervisor_pkg::MOD_TEMP_SET_C ||
        meas.module_temp[2] > supervisor_pkg::MOD_TEMP_SET_C)
      next_st.warn[supervisor_pkg::W_MOD_TEMP] = 1'b1;
    else if (meas.module_temp[0] < supervisor_pkg::MOD_TEMP_CLEAR_C &&
             meas.module_temp[1] < supervisor_pkg::MOD_TEMP_CLEAR_C &&
             meas.module_temp[2] < supervisor_pkg::MOD_TEMP_CLEAR_C)
      next_st.warn[supervisor_pkg::W_MOD_TEMP] = 1'b0;
    next_st.warn[supervisor_pkg::W_BOARD_TEMP] =
      hyst_over(st.warn[supervisor_pkg::W_BOARD_TEMP], meas.board_temp,
                supervisor_pkg::BOARD_TEMP_SET_C,
                supervisor_pkg::BOARD_TEMP_SET_C -
                supervisor_pkg::BOARD_TEMP_CLEAR_C);
    next_st.warn[supervisor_pkg::W_EXT_TEMP] = st.cfg.ext_therm_en[0] &&
      hyst_over(st.warn[supervisor_pkg::W_EXT_TEMP], meas.ext_temp,
                st.cfg.ext_warn, st.cfg.ext_delta);
    next_st.warn_ext[supervisor_pkg::WX_PLL]    = !meas.pll_locked;
    next_st.warn_ext[supervisor_pkg::WX_BIAS15] = !meas.bias15_ok;
    next_st.warn_ext[supervisor_pkg::WX_BIAS5]  = !meas.bias5_ok;

    // Fault latches: sources always set, so a set beats a clear
    if (clear_evt)
      next_st.latched = fault_sources;
    else if (auto_evt)
      next_st.latched = (st.latched & ~supervisor_pkg::GRID_FAULT_MASK) |
                        fault_sources;
    else
      next_st.latched = st.latched | fault_sources;

    // Reconnect timer runs only while the grid stays in tolerance
    if (st.state == supervisor_pkg::ST_FAULT && meas.freq_in_tol &&
        (&meas.grid_v_in_tol))
    begin
      if (tick && st.rc_cnt != 16'hFFFF)
        next_st.rc_cnt = st.rc_cnt + 16'h0001;
    end
    else
      next_st.rc_cnt = 16'h0000;

    case (st.state)
      supervisor_pkg::ST_CALIBRATE:
        if (calibration_done)
          next_st.state = supervisor_pkg::ST_WAIT_DC;
      supervisor_pkg::ST_WAIT_DC:
        if (sequence_ready)
          next_st.state = supervisor_pkg::ST_READY;
      supervisor_pkg::ST_READY:
        if (on_request)
          next_st.state = supervisor_pkg::ST_ON;
      supervisor_pkg::ST_ON:
        if (!on_request)
          next_st.state = supervisor_pkg::ST_READY;
      supervisor_pkg::ST_FAULT:
        // On requests are looked at only on an auto reconnect
        if (auto_evt)
          next_st.state = on_request ? supervisor_pkg::ST_ON :
                          calibration_done ? supervisor_pkg::ST_WAIT_DC :
                          supervisor_pkg::ST_CALIBRATE;
        else if (clear_evt && !any_src)
          next_st.state = calibration_done ? supervisor_pkg::ST_WAIT_DC :
                          supervisor_pkg::ST_CALIBRATE;
      default:
        next_st.state = supervisor_pkg::ST_FAULT;
    endcase
    if (any_src)
      next_st.state = supervisor_pkg::ST_FAULT;

    // Stage and contactors drop in the same edge that sees the fault
    next_st.power_on  = next_st.state == supervisor_pkg::ST_ON;
    next_st.contact   = next_st.state == supervisor_pkg::ST_READY ||
                        next_st.state == supervisor_pkg::ST_ON;
    next_st.fault_out = |next_st.latched;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st                     <= '0;
      st.state               <= supervisor_pkg::ST_CALIBRATE;
      st.cfg.reconnect_en    <= supervisor_pkg::ENABLE_RESET;
      st.cfg.reconnect_delay <= supervisor_pkg::DELAY_RESET;
      st.cfg.link_ov_warn    <= supervisor_pkg::OVER_LEVEL_RESET;
      st.cfg.link_uv_fault   <= supervisor_pkg::UNDER_LEVEL_RESET;
      st.cfg.link_uv_warn    <= supervisor_pkg::UNDER_LEVEL_RESET;
      st.cfg.cur_warn        <= supervisor_pkg::OVER_LEVEL_RESET;
      st.cfg.grid_ov_warn    <= supervisor_pkg::OVER_LEVEL_RESET;
      st.cfg.link_ov_delta   <= supervisor_pkg::DELTA_RESET;
      st.cfg.link_uv_delta   <= supervisor_pkg::DELTA_RESET;
      st.cfg.cur_delta       <= supervisor_pkg::DELTA_RESET;
      st.cfg.grid_ov_delta   <= supervisor_pkg::DELTA_RESET;
      st.cfg.pin_clear_en    <= supervisor_pkg::ENABLE_RESET;
      st.cfg.ext_therm_en    <= supervisor_pkg::ENABLE_RESET;
      st.cfg.ext_warn        <= supervisor_pkg::OVER_LEVEL_RESET;
      st.cfg.ext_delta       <= supervisor_pkg::DELTA_RESET;
    end
    else
      st <= next_st;
  end

  always_comb
  begin
    rdata               = st.rdata;
    power_stage_on      = st.power_on;
    contactor_close     = st.contact;
    fault_indicator_pin = st.fault_out;
    op_state            = st.state;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fault_stage_off: assert property (any_src |=> !power_stage_on &&
    !contactor_close && op_state == supervisor_pkg::ST_FAULT)
    else $error("fault did not stop stage and enter fault state");
  a_fault_state_hold: assert property (
    op_state == supervisor_pkg::ST_FAULT && !clear_evt && !auto_evt
    |=> op_state == supervisor_pkg::ST_FAULT)
    else $error("fault state left without a clear");
  a_fault_no_on: assert property (
    op_state == supervisor_pkg::ST_FAULT && on_request && !auto_evt
    |=> !power_stage_on)
    else $error("stage turned on from fault state");
  a_reconnect_on: assert property (
    auto_evt && on_request |=> op_state == supervisor_pkg::ST_ON &&
    (st.latched & supervisor_pkg::GRID_FAULT_MASK) == 32'h0000_0000)
    else $error("auto reconnect did not return to on");
  a_clear_exit_to: assert property (
    op_state == supervisor_pkg::ST_FAULT && clear_evt && !any_src &&
    !auto_evt |=> op_state == ($past(calibration_done) ?
    supervisor_pkg::ST_WAIT_DC : supervisor_pkg::ST_CALIBRATE))
    else $error("fault reset went to wrong state");
  a_clear_relatch: assert property (
    clear_evt |=> st.latched == $past(fault_sources))
    else $error("fault reset did not relatch active sources");
  a_latch_sticky: assert property (
    !clear_evt && !auto_evt |=>
    (st.latched & $past(st.latched)) == $past(st.latched))
    else $error("latched fault bit lost without clear");
  a_indicator_pin: assert property (
    fault_indicator_pin == (st.latched != 32'h0000_0000))
    else $error("fault indicator disagrees with latches");
  a_link_high_warn: assert property (
    meas.link_v > st.cfg.link_ov_warn |=>
    st.warn[supervisor_pkg::W_LINK_HIGH])
    else $error("link high warning not set");
  a_pll_warn: assert property (
    1'b1 |=> st.warn_ext[supervisor_pkg::WX_PLL] == !$past(meas.pll_locked))
    else $error("sync warning does not follow lock status");
  a_ext_warn_gate: assert property (
    !st.cfg.ext_therm_en[0] |=> !st.warn[supervisor_pkg::W_EXT_TEMP])
    else $error("external warning set while sensor disabled");

  c_fault_entry: cover property (op_state == supervisor_pkg::ST_ON ##1
    op_state == supervisor_pkg::ST_FAULT);
  c_clear_exit: cover property (op_state == supervisor_pkg::ST_FAULT ##1
    op_state == supervisor_pkg::ST_WAIT_DC);
  c_auto_reconnect: cover property (auto_evt);
  c_link_warn: cover property (st.warn[supervisor_pkg::W_LINK_HIGH]);

endmodule
`default_nettype wire

// ---- host_model.sv ----
// Host controller model: register writes and reads on the parameter port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output var  logic [15:0] addr,
  output var  logic [15:0] wdata,
  output var  logic        wr_en,
  output var  logic        rd_en
);
  initial
  begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Data inverted on release so a stale value is never mistaken for a write
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- fault_warning_supervisor_test.sv ----
// Self-checking testbench of the fault and warning supervisor
`timescale 1ns/100ps
`default_nettype none
module fault_warning_supervisor_test;
  logic clk = 1'b0, rst_n = 1'b0, on_req = 1'b0, cal = 1'b0, seq = 1'b0;
  logic pin = 1'b0, pwr, con, ind, wr_en, rd_en;
  logic [15:0] addr, wdata, rdata, d;
  logic [31:0] src = 32'h0;
  supervisor_pkg::meas_t m;
  supervisor_pkg::op_state_t st;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en));
  fault_warning_supervisor #(.TICK_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .meas(m), .fault_sources(src), .on_request(on_req),
    .calibration_done(cal), .sequence_ready(seq), .fault_clear_pin(pin),
    .power_stage_on(pwr), .contactor_close(con), .fault_indicator_pin(ind),
    .op_state(st));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic t_fault;
    {cal, seq, on_req} <= 3'b111;
    repeat (6) @(posedge clk);
    #1 chk({13'h0, st}, 16'h0003);
    @(posedge clk);
    src <= 32'h2;
    repeat (2) @(posedge clk);
    #1 chk({12'h0, pwr, con, ind, 1'b0}, 16'h0002);
    chk({13'h0, st}, 16'h0004);
    host.rd(16'h4016, d); chk(d, 16'h0002);
    host.wr(16'h0003, 16'h0000);
    #1 chk({13'h0, st}, 16'h0004);
    chk({15'h0, pwr}, 16'h0000);
    @(posedge clk);
    {src, seq} <= 33'h0;
    host.wr(16'h0003, 16'h0000);
    #1 chk({13'h0, st}, 16'h0001);
    chk({15'h0, ind}, 16'h0000);
    host.rd(16'h4016, d); chk(d, 16'h0000);
    $display("fault test done");
  endtask
  task automatic t_pin;
    {src, cal} <= 33'h10;
    @(posedge clk);
    src <= 32'h0;
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({13'h0, st}, 16'h0004);
    host.rd(16'h4016, d); chk(d, 16'h0008);
    host.rd(16'h4017, d); chk(d, 16'h0000);
    pin <= 1'b0;
    host.wr(16'h8063, 16'h0001);
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({13'h0, st}, 16'h0000);
    $display("pin clear test done");
  endtask
  task automatic t_warn(input logic [15:0] v, input logic [15:0] b,
                        input logic [15:0] w);
    m.link_v <= v;
    m.board_temp <= b;
    repeat (2) @(posedge clk);
    host.rd(16'h4015, d); chk(d, w);
  endtask
  // Grid-only fault must clear itself once the grid is back long enough
  task automatic t_auto;
    host.wr(16'h803E, 16'h0001);
    host.wr(16'h803F, 16'h0002);
    {cal, seq} <= 2'b11;
    repeat (4) @(posedge clk);
    #1 chk({13'h0, st}, 16'h0003);
    @(posedge clk);
    src <= 32'h40;
    m.grid_v_in_tol <= 3'b110;
    @(posedge clk);
    src <= 32'h0;
    m.grid_v_in_tol <= 3'b111;
    repeat (6) @(posedge clk);
    #1 chk({13'h0, st}, 16'h0004);
    repeat (14) @(posedge clk);
    #1 chk({12'h0, st, pwr}, 16'h0007);
    host.rd(16'h4016, d); chk(d, 16'h0000);
    $display("auto reconnect test done");
  endtask
  initial
  begin
    m = '0;
    m.link_v = 16'h0200;
    {m.freq_in_tol, m.grid_v_in_tol, m.pll_locked} = 5'h1F;
    {m.bias15_ok, m.bias5_ok} = 2'h3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    host.rd(16'h4015, d); chk(d, 16'h0000);
    host.rd(16'h1234, d); chk(d, 16'h0000);
    $display("reset test done");
    t_fault();
    t_pin();
    host.wr(16'h8045, 16'h03E8);
    host.wr(16'h8052, 16'h0064);
    t_warn(16'h03E9, 16'h0056, 16'h4001);
    t_warn(16'h0384, 16'h0050, 16'h4001);
    m.pll_locked <= 1'b0;
    m.bias5_ok <= 1'b0;
    t_warn(16'h0383, 16'h004F, 16'h0000);
    host.wr(16'h8046, 16'h012C);
    host.wr(16'h8047, 16'h0190);
    host.wr(16'h8053, 16'h0032);
    t_warn(16'h0100, 16'h004F, 16'h0006);
    t_warn(16'h01C2, 16'h004F, 16'h0002);
    t_warn(16'h01C3, 16'h004F, 16'h0000);
    host.rd(16'h4020, d); chk(d, 16'h0005);
    chk({13'h0, st}, 16'h0000);
    $display("warning test done");
    t_auto();
    summarize();
  end
endmodule
`default_nettype wire
